// File: mcp_checker.sv
// Assertions on the module control pin outputs
`timescale 1ns/1ps
module mcp_checker
  import mcp_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC // Init wait
) (
  input logic                 clk_i,              // Clock
  input logic                 reset_n_i,          // Reset
  input logic                 module_select_n_i,  // Select
  input logic                 select_driven_i,    // Select driven
  input logic                 module_reset_n_i,   // Host reset
  input logic                 low_power_select_i, // Low power
  input logic [NUM_FLAGS-1:0] fault_event_i,      // Events
  input logic [NUM_FLAGS-1:0] fault_mask_i,       // Masks
  input logic                 flag_read_i,        // Flag read
  input logic                 mgmt_sda_oe_req_i,  // Drive wish
  input logic                 mgmt_sda_o_req_i,   // Data wish
  input logic                 mgmt_enable_o,      // Bus enable
  input logic                 mgmt_sda_o,         // Bus data
  input logic                 mgmt_sda_oe_o,      // Bus drive
  input logic                 settings_default_o, // Full reset
  input logic                 low_power_o,        // Low power
  input logic                 module_present_n_o, // Presence
  input logic                 module_present_n_oe_o, // Presence drive
  input logic                 attention_n_o,      // Attention
  input logic                 attention_n_oe_o,   // Attention drive
  input logic [7:0]           status_byte_o,      // Status
  input logic                 ready_o             // Ready
);
  logic [5:0]       low_cnt_q;
  logic [CNT_W-1:0] init_cnt_q;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt_q <= 6'h00;
    end else if (module_reset_n_i) begin
      low_cnt_q <= 6'h00;
    end else if (low_cnt_q != 6'h3f) begin
      low_cnt_q <= low_cnt_q + 6'h01;
    end
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_cnt_q <= CNT_ZERO;
    end else if (settings_default_o) begin
      init_cnt_q <= CNT_ZERO;
    end else if (!ready_o) begin
      init_cnt_q <= init_cnt_q + CNT_ONE;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_done;
    attention_n_oe_o && !status_byte_o[DATA_PEND_BIT];
  endsequence
  sequence s_cause;
    ready_o && (fault_event_i & ~fault_mask_i) != FLAGS_ZERO;
  endsequence
  property p_deselect;
    (module_select_n_i || !select_driven_i) |=> !mgmt_enable_o && !mgmt_sda_oe_o;
  endproperty
  property p_select;
    (!module_select_n_i && select_driven_i && module_reset_n_i && !settings_default_o)
      |=> mgmt_enable_o && mgmt_sda_oe_o == $past(mgmt_sda_oe_req_i)
          && (!mgmt_sda_oe_o || mgmt_sda_o == $past(mgmt_sda_o_req_i));
  endproperty
  property p_lowpwr;
    1'b1 |=> low_power_o == $past(low_power_select_i);
  endproperty
  property p_pins;
    module_present_n_oe_o && !module_present_n_o && !attention_n_o;
  endproperty
  property p_long;
    low_cnt_q >= 6'h16 |-> settings_default_o;
  endproperty
  property p_short;
    (low_cnt_q <= 6'h10 && !settings_default_o) |=> !settings_default_o;
  endproperty
  property p_held;
    settings_default_o |-> ##2 status_byte_o[DATA_PEND_BIT] && !ready_o;
  endproperty
  property p_init_max;
    (!ready_o && !settings_default_o) |-> init_cnt_q <= INIT_CYCLES + 4;
  endproperty
  property p_init_min;
    $rose(ready_o) |-> init_cnt_q + 3 >= INIT_CYCLES;
  endproperty
  property p_done;
    $rose(ready_o) |-> ##[0:3] s_done;
  endproperty
  property p_raise;
    s_cause |-> ##[1:3] attention_n_oe_o;
  endproperty
  property p_release;
    (flag_read_i && fault_event_i == FLAGS_ZERO) ##1 (fault_event_i == FLAGS_ZERO) [*3]
      |-> !attention_n_oe_o;
  endproperty
  a_deselect: assert property (p_deselect) else $error("bus active while deselected");
  a_select: assert property (p_select) else $error("bus not passed while selected");
  a_lowpwr: assert property (p_lowpwr) else $error("low power not followed");
  a_pins: assert property (p_pins) else $error("pin value wrong");
  a_long: assert property (p_long) else $error("long reset not taken");
  a_short: assert property (p_short) else $error("short reset taken");
  a_held: assert property (p_held) else $error("status valid in reset");
  a_init_max: assert property (p_init_max) else $error("init too long");
  a_init_min: assert property (p_init_min) else $error("init too short");
  a_done: assert property (p_done) else $error("no completion attention");
  a_raise: assert property (p_raise) else $error("no attention on event");
  a_release: assert property (p_release) else $error("attention held");
endmodule
bind mcp_control_pins mcp_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.clk_i, .reset_n_i,
  .module_select_n_i, .select_driven_i, .module_reset_n_i, .low_power_select_i,
  .fault_event_i, .fault_mask_i, .flag_read_i, .mgmt_sda_oe_req_i, .mgmt_sda_o_req_i,
  .mgmt_enable_o, .mgmt_sda_o, .mgmt_sda_oe_o, .settings_default_o, .low_power_o,
  .module_present_n_o, .module_present_n_oe_o, .attention_n_o, .attention_n_oe_o,
  .status_byte_o, .ready_o);

// File: mcp_control_pins.sv
// Module control pins: select gating, reset, low power, presence, attention
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Select low lets the management bus slave answer commands.
// - Select high: bus traffic ignored, nothing driven onto the bus.
// - Select is pulled up inside; undriven select means deselected.
// - Reset held low past least width resets all user settings.
// - Initialization interval timed from the releasing rising edge.
// - Completion shown by attention low with data-pending flag cleared.
// - Completion attention raised on its own after power-up.
// - Low-power select is active high; selects reduced-consumption state.
// - Presence reads low when seated, high via host pull-up otherwise.
// - Attention driven low for faults or critical status.
// - Attention is open collector: pull low or release only.
// - Module fully functional within 2000 ms of power-on or reset.
// - Data-pending flag is bit 0 of status byte 2.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module mcp_control_pins
  import mcp_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = INIT_CYC  // Initialization wait in cycles
) (
  input  wire logic                 clk_i,              // System clock, 10 MHz
  input  wire logic                 reset_n_i,          // Power-on reset, active low
  input  wire logic                 module_select_n_i,  // Select pin, pull-up applied
  input  wire logic                 select_driven_i,    // Host drives select pin
  input  wire logic                 module_reset_n_i,   // Host reset pin
  input  wire logic                 low_power_select_i, // Low-power select, active high
  input  wire logic [NUM_FLAGS-1:0] fault_event_i,      // Fault and status events
  input  wire logic [NUM_FLAGS-1:0] fault_mask_i,       // Event masks from control
  input  wire logic                 flag_read_i,        // Host read latched flags
  input  wire logic                 mgmt_sda_oe_req_i,  // Bus slave wants to drive data
  input  wire logic                 mgmt_sda_o_req_i,   // Bus slave data value
  output logic                      mgmt_enable_o,      // Bus slave may answer
  output logic                      mgmt_sda_o,         // Bus data output
  output logic                      mgmt_sda_oe_o,      // Bus data enable, high drives
  output logic                      settings_default_o, // Return settings to default
  output logic                      low_power_o,        // Reduced-consumption state
  output logic                      module_present_n_o, // Presence pin level
  output logic                      module_present_n_oe_o, // Presence pin drive enable
  output logic                      attention_n_o,      // Attention output value
  output logic                      attention_n_oe_o,   // Attention pulls low when high
  output logic [7:0]                status_byte_o,      // Status byte 2 contents
  output logic [NUM_FLAGS-1:0]      flags_o,            // Latched flags for readout
  output logic                      ready_o             // Module fully functional
);
  import mcp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  logic full_reset;
  logic release_pulse;
  logic pending;
  logic select_n_eff;
  logic [NUM_FLAGS-1:0] flags;

  // Undriven select floats high through the internal pull-up
  assign select_n_eff = select_driven_i ? module_select_n_i : 1'b1;

  mcp_reset_filter u_reset_filter (
    .clk_i            (clk_i),
    .reset_n_i        (reset_n_i),
    .module_reset_n_i (module_reset_n_i),
    .full_reset_o     (full_reset),
    .release_o        (release_pulse)
  );

  mcp_flag_latch u_flag_latch (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .clear_all_i (full_reset),
    .event_i     (fault_event_i),
    .mask_i      (fault_mask_i),
    .flag_read_i (flag_read_i),
    .flags_o     (flags),
    .pending_o   (pending)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Initialization sequencer
  mcp_state_e       state_q;
  logic [CNT_W-1:0] init_cnt_q;
  logic             done_evt_q;   // Completion attention pending
  logic [7:0]       status_q;

  // Last cycle of the initialization interval
  function automatic logic init_last(input logic [CNT_W-1:0] cnt);
    return cnt >= CNT_W'(INIT_CYCLES - 1);
  endfunction

  // Power-up starts in INIT so completion is posted without a host reset
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= MCP_INIT;
    end else if (release_pulse) begin
      // Release wins: the qualified reset is still seen in this cycle
      state_q <= MCP_INIT;
    end else if (full_reset) begin
      state_q <= MCP_HELD;
    end else begin
      unique case (state_q)
        MCP_HELD: begin
          state_q <= MCP_HELD;
        end
        MCP_INIT: begin
          if (init_last(init_cnt_q)) begin
            state_q <= MCP_READY;
          end
        end
        MCP_READY: begin
          state_q <= MCP_READY;
        end
        default: begin
          state_q <= MCP_HELD;
        end
      endcase
    end
  end

  // Counts cycles spent in INIT; any other state restarts it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_cnt_q <= CNT_ZERO;
    end else if (state_q == MCP_INIT) begin
      init_cnt_q <= init_cnt_q + CNT_ONE;
    end else begin
      init_cnt_q <= CNT_ZERO;
    end
  end

  // Data-pending flag set through init, cleared on completion
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_q <= STATUS_RESET;
    end else if (state_q != MCP_READY) begin
      status_q[DATA_PEND_BIT] <= 1'b1;
    end else begin
      status_q[DATA_PEND_BIT] <= 1'b0;
    end
  end

  // Completion event held until the host reads the flags
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done_evt_q <= 1'b0;
    end else if (full_reset) begin
      done_evt_q <= 1'b0;
    end else if (state_q == MCP_INIT && init_last(init_cnt_q)) begin
      done_evt_q <= 1'b1;
    end else if (flag_read_i) begin
      done_evt_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin outputs
  logic ready_now;
  logic attention_cause;
  logic bus_open;
  assign ready_now = (state_q == MCP_READY);
  // Completion waits until the status copy shows data-pending cleared
  assign attention_cause = ready_now &&
    ((done_evt_q && !status_q[DATA_PEND_BIT]) || pending);
  // Bus passes only while selected and outside a qualified reset
  assign bus_open = !select_n_eff && !full_reset;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      attention_n_oe_o <= 1'b0;
    end else begin
      // Pull low for completion or any unmasked pending condition
      attention_n_oe_o <= attention_cause;
    end
  end

  // Open collector: value is always low, only the enable moves
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      attention_n_o <= 1'b0;
    end else begin
      attention_n_o <= 1'b0;
    end
  end

  // Seated module grounds the presence pin
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      module_present_n_o <= 1'b0;
    end else begin
      module_present_n_o <= 1'b0;
    end
  end

  // Ground always driven; only an empty slot lets the host pull-up show
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      module_present_n_oe_o <= 1'b1;
    end else begin
      module_present_n_oe_o <= 1'b1;
    end
  end

  // Power state follows the pin one cycle later
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_power_o <= 1'b0;
    end else begin
      low_power_o <= low_power_select_i;
    end
  end

  // Stands for as long as the qualified reset stands
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settings_default_o <= 1'b1;
    end else begin
      settings_default_o <= full_reset;
    end
  end

  // Management bus gating by select
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mgmt_enable_o <= 1'b0;
    end else if (bus_open) begin
      mgmt_enable_o <= 1'b1;
    end else begin
      mgmt_enable_o <= 1'b0;
    end
  end

  // Deselected: the data line is released, never driven
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mgmt_sda_oe_o <= 1'b0;
    end else if (bus_open) begin
      mgmt_sda_oe_o <= mgmt_sda_oe_req_i;
    end else begin
      mgmt_sda_oe_o <= 1'b0;
    end
  end

  // Data held low while the bus is closed so no stale bit leaks out
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mgmt_sda_o <= 1'b0;
    end else if (bus_open) begin
      mgmt_sda_o <= mgmt_sda_o_req_i;
    end else begin
      mgmt_sda_o <= 1'b0;
    end
  end

  // Status byte as the bus slave reads it
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_byte_o <= STATUS_RESET;
    end else begin
      status_byte_o <= status_q;
    end
  end

  // Latched flags for the bus slave readout
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_o <= FLAGS_ZERO;
    end else begin
      flags_o <= flags;
    end
  end

  // Fully functional once initialization has ended
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= ready_now;
    end
  end

endmodule

// File: mcp_flag_latch.sv
// Latched interrupt condition flags with host clear
`timescale 1ns/1ps
module mcp_flag_latch
  import mcp_pkg::*;
(
  input  wire logic                 clk_i,       // System clock
  input  wire logic                 reset_n_i,   // Async reset, active low
  input  wire logic                 clear_all_i, // Full reset clears flags
  input  wire logic [NUM_FLAGS-1:0] event_i,     // Condition events
  input  wire logic [NUM_FLAGS-1:0] mask_i,      // Mask, 1 hides a flag
  input  wire logic                 flag_read_i, // Host read the flags
  output logic      [NUM_FLAGS-1:0] flags_o,     // Latched flags
  output logic                      pending_o    // Unmasked flag set
);
  import mcp_pkg::*;

  logic [NUM_FLAGS-1:0] flags_q;
  logic [NUM_FLAGS-1:0] flags_d;

  // A new event wins over the read-clear in the same cycle
  always_comb begin
    flags_d = flags_q;
    if (flag_read_i) begin
      flags_d = FLAGS_ZERO;
    end
    flags_d = flags_d | event_i;
    if (clear_all_i) begin
      flags_d = FLAGS_ZERO;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_q <= FLAGS_ZERO;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags_o   = flags_q;
  assign pending_o = |(flags_q & ~mask_i);

endmodule

// File: mcp_host_model.sv
// Host board model: pull-ups on the presence and attention lines
`timescale 1ns/1ps
module mcp_host_model (
  input  logic att_n_i,    // Attention value
  input  logic att_oe_i,   // Attention pulled low
  input  logic prs_n_i,    // Presence value
  input  logic prs_oe_i,   // Presence driven
  output logic att_pin_o,  // Attention line level
  output logic prs_pin_o   // Presence line level
);
  assign att_pin_o = att_oe_i ? att_n_i : 1'b1;
  assign prs_pin_o = prs_oe_i ? prs_n_i : 1'b1;
endmodule

// File: mcp_pkg.sv
// Constants and types shared by the module control pin logic
package mcp_pkg;

  // Clock rate in kHz (10 MHz)
  localparam int unsigned CLK_KHZ         = 10000;
  // Least reset pulse width in ns
  localparam int unsigned RESET_MIN_NS    = 2000;
  localparam int unsigned CLK_PERIOD_NS   = 100;
  // Least time rounds up
  localparam int unsigned RESET_MIN_CYC   =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Initialization time in ms; longest time rounds down
  localparam int unsigned INIT_MS         = 2000;
  localparam int unsigned INIT_CYC        = INIT_MS * CLK_KHZ;

  localparam int unsigned CNT_W           = 25;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 25'h0000000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 25'h0000001;

  // Status byte 2 of management memory, data-pending flag position
  localparam int unsigned STATUS_BYTE_IDX = 2;
  localparam int unsigned DATA_PEND_BIT   = 0;
  localparam logic [7:0]  STATUS_RESET    = 8'h01;

  // Number of interrupt condition sources
  localparam int unsigned NUM_FLAGS       = 8;
  localparam logic [NUM_FLAGS-1:0] FLAGS_ZERO = 8'h00;

  typedef enum logic [1:0] {
    MCP_HELD,
    MCP_INIT,
    MCP_READY
  } mcp_state_e;

endpackage

// File: mcp_reset_filter.sv
// Qualifies host reset pulses against the least pulse width
`timescale 1ns/1ps
module mcp_reset_filter
  import mcp_pkg::*;
(
  input  wire logic clk_i,          // System clock
  input  wire logic reset_n_i,      // Async reset, active low
  input  wire logic module_reset_n_i, // Host reset pin level
  output logic      full_reset_o,   // Qualified reset is pending
  output logic      release_o       // Pulse on rising edge ending a reset
);
  import mcp_pkg::*;

  logic [CNT_W-1:0] low_cnt_q;
  logic             pin_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_cnt_q <= CNT_ZERO;
    end else if (module_reset_n_i) begin
      low_cnt_q <= CNT_ZERO;
    end else if (low_cnt_q < CNT_W'(RESET_MIN_CYC)) begin
      low_cnt_q <= low_cnt_q + CNT_ONE;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= module_reset_n_i;
    end
  end

  // Low longer than the least width counts as a full reset
  assign full_reset_o = (low_cnt_q >= CNT_W'(RESET_MIN_CYC));
  // Init interval starts at the releasing rising edge
  assign release_o = full_reset_o && module_reset_n_i && !pin_q;

endmodule

// File: tb.sv
// Testbench for the module control pin logic
`timescale 1ns/1ps
module tb;
  import mcp_pkg::*;
  localparam int unsigned INIT_SIM = 50;
  logic clk_i, reset_n_i, module_select_n_i, select_driven_i, module_reset_n_i;
  logic low_power_select_i, flag_read_i, mgmt_sda_oe_req_i, mgmt_sda_o_req_i;
  logic mgmt_enable_o, mgmt_sda_o, mgmt_sda_oe_o, settings_default_o, low_power_o;
  logic module_present_n_o, module_present_n_oe_o, attention_n_o, attention_n_oe_o;
  logic ready_o, att_pin, prs_pin;
  logic [7:0] fault_event_i, fault_mask_i, status_byte_o, flags_o;
  int   num_errors = 0;
  int   cmp_count = 0;
  int   n;
  mcp_control_pins #(.INIT_CYCLES(INIT_SIM)) dut (.clk_i, .reset_n_i, .module_select_n_i,
    .select_driven_i, .module_reset_n_i, .low_power_select_i, .fault_event_i,
    .fault_mask_i, .flag_read_i, .mgmt_sda_oe_req_i, .mgmt_sda_o_req_i, .mgmt_enable_o,
    .mgmt_sda_o, .mgmt_sda_oe_o, .settings_default_o, .low_power_o, .module_present_n_o,
    .module_present_n_oe_o, .attention_n_o, .attention_n_oe_o, .status_byte_o, .flags_o,
    .ready_o);
  mcp_host_model host (.att_n_i(attention_n_o), .att_oe_i(attention_n_oe_o),
    .prs_n_i(module_present_n_o), .prs_oe_i(module_present_n_oe_o), .att_pin_o(att_pin),
    .prs_pin_o(prs_pin));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(string name, logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic go(int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic wait_ready();
    n = 0;
    while (ready_o !== 1'b1 && n < INIT_SIM + 20) begin
      @(negedge clk_i);
      n++;
    end
    go(4);
    @(negedge clk_i);
  endtask
  task automatic read_flags();
    @(posedge clk_i) flag_read_i <= 1'b1;
    @(posedge clk_i) flag_read_i <= 1'b0;
    go(3);
    @(negedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    reset_n_i = 1'b0;
    module_select_n_i = 1'b1;
    select_driven_i = 1'b0;
    module_reset_n_i = 1'b1;
    low_power_select_i = 1'b0;
    flag_read_i = 1'b0;
    mgmt_sda_oe_req_i = 1'b1;
    mgmt_sda_o_req_i = 1'b1;
    fault_event_i = 8'h00;
    fault_mask_i = 8'h00;
    go(2);
    reset_n_i <= 1'b1;
    @(negedge clk_i);
    chk("status", status_byte_o, STATUS_RESET);
    wait_ready();
    chk("init_in_time", n <= INIT_SIM + 4, 1'b1);
    chk("data_pending", status_byte_o[DATA_PEND_BIT], 1'b0);
    chk("attention_pin", att_pin, 1'b0);
    chk("present_pin", prs_pin, 1'b0);
    read_flags();
    chk("attention_pin", att_pin, 1'b1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      select_driven_i <= i[1];
      module_select_n_i <= i[0];
      mgmt_sda_o_req_i <= !i[0];
      go(2);
      @(negedge clk_i);
      chk("bus_enable", mgmt_enable_o, i == 2);
      chk("bus_drive", mgmt_sda_oe_o, i == 2);
      chk("bus_data", mgmt_sda_o, i == 2);
    end
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk_i) low_power_select_i <= i[0];
      go(2);
      @(negedge clk_i);
      chk("low_power", low_power_o, i[0]);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i) begin
        fault_mask_i <= i ? 8'h20 : 8'h00;
        fault_event_i <= 8'h20;
      end
      @(posedge clk_i) fault_event_i <= 8'h00;
      go(3);
      @(negedge clk_i);
      chk("flags", flags_o, 8'h20);
      chk("attention_pin", att_pin, i == 1);
      read_flags();
      chk("flags", flags_o, 8'h00);
      chk("attention_pin", att_pin, 1'b1);
    end
    for (int len = 10; len < 30; len += 15) begin
      @(posedge clk_i) module_reset_n_i <= 1'b0;
      go(len);
      @(negedge clk_i);
      chk("settings_default", settings_default_o, len > 20);
      chk("ready", ready_o, len < 20);
      chk("data_pending", status_byte_o[DATA_PEND_BIT], len > 20);
      @(posedge clk_i) module_reset_n_i <= 1'b1;
      if (len > 20) begin
        wait_ready();
        chk("init_time", n >= INIT_SIM - 1 && n <= INIT_SIM + 4, 1'b1);
        chk("attention_pin", att_pin, 1'b0);
      end
    end
    report_and_stop();
  end
  initial begin
    #(100 * 3000);
    num_errors++;
    report_and_stop();
  end
endmodule
